// file: core/pcm_pkg.sv
// pump condition monitor: constants, register map, reset values, press-sequence states
// assumes a 200 MHz clock; all slow timing is counted in 0.2 s ticks
package pcm_pkg;

    // =======================================================
    // timing
    localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
    localparam int unsigned TICK_PERIOD_MS   = 200;
    localparam int unsigned TICK_CYCLES      = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
    localparam int unsigned HEARTBEAT_MS     = 1000;
    localparam int unsigned HEARTBEAT_TICKS  = HEARTBEAT_MS / TICK_PERIOD_MS;
    localparam int unsigned HEARTBEAT_LOW    = 2;
    localparam int unsigned LONG_PRESS_MS    = 3000;
    localparam int unsigned LONG_PRESS_TICKS = (LONG_PRESS_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS;
    localparam int unsigned SHORT_MAX_MS     = 1000;
    localparam int unsigned SHORT_MAX_TICKS  = SHORT_MAX_MS / TICK_PERIOD_MS;
    localparam int unsigned GAP_MAX_MS       = 2000;
    localparam int unsigned GAP_MAX_TICKS    = GAP_MAX_MS / TICK_PERIOD_MS;
    localparam int unsigned CONFIRM_MS       = 5000;
    localparam int unsigned CONFIRM_TICKS    = CONFIRM_MS / TICK_PERIOD_MS;
    localparam int unsigned STARTUP_MS       = 5000;
    localparam int unsigned STARTUP_TICKS    = STARTUP_MS / TICK_PERIOD_MS;
    localparam int unsigned HOUR_MS          = 3_600_000;
    localparam int unsigned HOUR_TICKS       = HOUR_MS / TICK_PERIOD_MS;

    // =======================================================
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_VIB_WARN  = 8'h08;
    localparam logic [7:0] ADDR_VIB_FAIL  = 8'h0C;
    localparam logic [7:0] ADDR_HYST      = 8'h10;
    localparam logic [7:0] ADDR_TEMP_WARN = 8'h14;
    localparam logic [7:0] ADDR_TEMP_FAIL = 8'h18;
    localparam logic [7:0] ADDR_RUN_THR   = 8'h1C;
    localparam logic [7:0] ADDR_HOURS     = 8'h20;
    localparam logic [7:0] ADDR_READINGS  = 8'h24;

    // control and status fields
    localparam int CTRL_INVERT   = 0;
    localparam int CTRL_CLEAR    = 1;
    localparam int ST_WARN       = 0;
    localparam int ST_FAIL       = 1;
    localparam int ST_TURNING    = 2;
    localparam int ST_STARTUP    = 3;
    localparam int ST_CONFIRM    = 4;
    localparam int ST_HEARTBEAT  = 5;
    localparam int ST_FAIL_NOW   = 6;
    localparam int RD_VIB_POS    = 16;

    // values after reset
    localparam logic [9:0] VIB_WARN_RST  = 10'h064;
    localparam logic [9:0] VIB_FAIL_RST  = 10'h096;
    localparam logic [7:0] HYST_RST      = 8'h0A;
    localparam logic [7:0] TEMP_WARN_RST = 8'h3C;
    localparam logic [7:0] TEMP_FAIL_RST = 8'h46;
    localparam logic [9:0] RUN_THR_RST   = 10'h00F;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // reset push-button sequence
    typedef enum logic [5:0] {
        PB_IDLE   = 6'b000001,
        PB_LONG   = 6'b000010,
        PB_GAP1   = 6'b000100,
        PB_SHORT1 = 6'b001000,
        PB_GAP2   = 6'b010000,
        PB_SHORT2 = 6'b100000
    } pcm_press_t;

endpackage : pcm_pkg

// file: core/pcm_monitor.sv
// pump condition monitor: limit comparators, switching outputs, reset button, axi4-lite regs
// assumes sensor readings and the button arrive asynchronously; readings are slow and
// quasi-static, so a plain two-flop pass is enough for them
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module pcm_monitor #(
    parameter int unsigned TEMP_W      = 8,
    parameter int unsigned VIB_W       = 10,
    parameter int unsigned TICK_CYCLES = pcm_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // axi4-lite write
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // sensors and button
    input  wire logic [TEMP_W-1:0] oil_temperature_probe,
    input  wire logic [VIB_W-1:0]  vibration_level,
    input  wire logic              reset_button_n,
    // switching outputs and indications
    output logic                   warning_output,
    output logic                   failure_output,
    output logic                   heartbeat_output,
    output logic                   rotor_turning_output,
    output logic                   pump_running,
    output logic                   reset_confirm
);

    // =======================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // =======================================================
    // input synchronisers
    logic [TEMP_W-1:0] temp_s1, temp;
    logic [VIB_W-1:0]  vib_s1, vib;
    logic              btn_s1, btn_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_s1 <= '0;
            temp    <= '0;
            vib_s1  <= '0;
            vib     <= '0;
            btn_s1  <= 1'b1;
            btn_n   <= 1'b1;
        end else begin
            temp_s1 <= oil_temperature_probe;
            temp    <= temp_s1;
            vib_s1  <= vibration_level;
            vib     <= vib_s1;
            btn_s1  <= reset_button_n;
            btn_n   <= btn_s1;
        end
    end

    // =======================================================
    // 0.2 s tick
    logic [31:0] tick_cnt;
    logic        tick;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'd1;
            tick     <= 1'b0;
        end
    end

    // =======================================================
    // configuration
    logic [VIB_W-1:0]  vib_warn_lim, vib_fail_lim, run_thr;
    logic [7:0]        hyst;
    logic [TEMP_W-1:0] temp_warn_lim, temp_fail_lim;
    logic              invert;
    logic              sw_clear;
    logic              wr_go;
    logic [7:0]        wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;

    // defaults loaded at reset, adjustable afterwards
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vib_warn_lim  <= VIB_W'(pcm_pkg::VIB_WARN_RST);
            vib_fail_lim  <= VIB_W'(pcm_pkg::VIB_FAIL_RST);
            hyst          <= pcm_pkg::HYST_RST;
            temp_warn_lim <= TEMP_W'(pcm_pkg::TEMP_WARN_RST);
            temp_fail_lim <= TEMP_W'(pcm_pkg::TEMP_FAIL_RST);
            run_thr       <= VIB_W'(pcm_pkg::RUN_THR_RST);
            invert        <= 1'b0;
            sw_clear      <= 1'b0;
        end else begin
            sw_clear <= 1'b0;
            if (wr_go) begin
                case (wr_addr)
                    pcm_pkg::ADDR_CTRL: begin
                        invert   <= wr_strb[0] ? wr_data[pcm_pkg::CTRL_INVERT] : invert;
                        sw_clear <= wr_strb[0] & wr_data[pcm_pkg::CTRL_CLEAR];
                    end
                    pcm_pkg::ADDR_VIB_WARN:
                        vib_warn_lim <= VIB_W'(merge(32'(vib_warn_lim), wr_data, wr_strb));
                    pcm_pkg::ADDR_VIB_FAIL:
                        vib_fail_lim <= VIB_W'(merge(32'(vib_fail_lim), wr_data, wr_strb));
                    pcm_pkg::ADDR_HYST:
                        hyst <= 8'(merge(32'(hyst), wr_data, wr_strb));
                    pcm_pkg::ADDR_TEMP_WARN:
                        temp_warn_lim <= TEMP_W'(merge(32'(temp_warn_lim), wr_data, wr_strb));
                    pcm_pkg::ADDR_TEMP_FAIL:
                        temp_fail_lim <= TEMP_W'(merge(32'(temp_fail_lim), wr_data, wr_strb));
                    pcm_pkg::ADDR_RUN_THR:
                        run_thr <= VIB_W'(merge(32'(run_thr), wr_data, wr_strb));
                    default: begin
                    end
                endcase
            end
        end
    end

    // =======================================================
    // vibration comparators with persistence: 0 warn, 1 fail, 2 running
    logic [2:0] vib_raw, vib_state;
    logic [7:0] hyst_cnt [3];

    assign vib_raw[0] = vib > vib_warn_lim;
    assign vib_raw[1] = vib > vib_fail_lim;
    assign vib_raw[2] = vib > run_thr;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vib_state <= '0;
            for (int i = 0; i < 3; i++) begin
                hyst_cnt[i] <= '0;
            end
        end else if (tick) begin
            for (int i = 0; i < 3; i++) begin
                if (vib_raw[i] == vib_state[i]) begin
                    hyst_cnt[i] <= '0;
                end else if (hyst_cnt[i] + 8'd1 >= hyst) begin
                    vib_state[i] <= vib_raw[i];
                    hyst_cnt[i]  <= '0;
                end else begin
                    hyst_cnt[i] <= hyst_cnt[i] + 8'd1;
                end
            end
        end
    end

    // =======================================================
    // start-up window: vibration limits ignored while the pump runs up
    logic [7:0] startup_cnt;
    logic       turning_d;
    logic       startup;

    assign startup = startup_cnt != 8'd0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startup_cnt <= '0;
            turning_d   <= 1'b0;
        end else begin
            turning_d <= vib_state[2];
            if (vib_state[2] && !turning_d) begin
                startup_cnt <= 8'(pcm_pkg::STARTUP_TICKS);
            end else if (tick && startup) begin
                startup_cnt <= startup_cnt - 8'd1;
            end
        end
    end

    // =======================================================
    // warning and failure conditions
    logic warn_now, fail_now, fail_latch;
    logic accept_clear;

    assign warn_now = (temp >= temp_warn_lim) || (vib_state[0] && !startup);
    assign fail_now = (temp >= temp_fail_lim) || (vib_state[1] && !startup);

    // a new failure wins over a clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fail_latch <= 1'b0;
        end else if (fail_now) begin
            fail_latch <= 1'b1;
        end else if (accept_clear) begin
            fail_latch <= 1'b0;
        end
    end

    // =======================================================
    // reset button: long press then two short presses
    pcm_pkg::pcm_press_t pb_state;
    logic [7:0]  pb_cnt;
    logic        pb_done;
    logic [7:0]  confirm_cnt;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pb_state <= pcm_pkg::PB_IDLE;
            pb_cnt   <= '0;
            pb_done  <= 1'b0;
        end else begin
            pb_done <= 1'b0;
            if (tick) begin
                pb_cnt <= (pb_cnt == 8'hFF) ? pb_cnt : pb_cnt + 8'd1;
            end
            case (pb_state)
                pcm_pkg::PB_IDLE: begin
                    pb_cnt <= '0;
                    if (!btn_n) begin
                        pb_state <= pcm_pkg::PB_LONG;
                    end
                end
                pcm_pkg::PB_LONG: begin
                    if (btn_n) begin
                        pb_cnt   <= '0;
                        pb_state <= (pb_cnt >= 8'(pcm_pkg::LONG_PRESS_TICKS)) ?
                                    pcm_pkg::PB_GAP1 : pcm_pkg::PB_IDLE;
                    end
                end
                pcm_pkg::PB_GAP1, pcm_pkg::PB_GAP2: begin
                    if (!btn_n) begin
                        pb_cnt   <= '0;
                        pb_state <= (pb_state == pcm_pkg::PB_GAP1) ?
                                    pcm_pkg::PB_SHORT1 : pcm_pkg::PB_SHORT2;
                    end else if (pb_cnt > 8'(pcm_pkg::GAP_MAX_TICKS)) begin
                        pb_state <= pcm_pkg::PB_IDLE;
                    end
                end
                pcm_pkg::PB_SHORT1, pcm_pkg::PB_SHORT2: begin
                    if (pb_cnt > 8'(pcm_pkg::SHORT_MAX_TICKS)) begin
                        // too long to be a short press: start over
                        pb_state <= pcm_pkg::PB_LONG;
                    end else if (btn_n) begin
                        pb_cnt <= '0;
                        if (pb_state == pcm_pkg::PB_SHORT1) begin
                            pb_state <= pcm_pkg::PB_GAP2;
                        end else begin
                            pb_state <= pcm_pkg::PB_IDLE;
                            pb_done  <= 1'b1;
                        end
                    end
                end
                default: pb_state <= pcm_pkg::PB_IDLE;
            endcase
        end
    end

    // refused silently while the cause is still present
    assign accept_clear = (pb_done || sw_clear) && !fail_now;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            confirm_cnt <= '0;
        end else if (accept_clear) begin
            confirm_cnt <= 8'(pcm_pkg::CONFIRM_TICKS);
        end else if (tick && confirm_cnt != 8'd0) begin
            confirm_cnt <= confirm_cnt - 8'd1;
        end
    end

    // =======================================================
    // heartbeat and operating hours
    logic [7:0]  hb_cnt;
    logic [15:0] hour_cnt;
    logic [31:0] hours;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hb_cnt <= '0;
        end else if (tick) begin
            hb_cnt <= (hb_cnt == 8'(pcm_pkg::HEARTBEAT_TICKS - 1)) ? 8'd0 : hb_cnt + 8'd1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hour_cnt <= '0;
            hours    <= '0;
        end else if (tick && vib_state[2]) begin
            if (hour_cnt == 16'(pcm_pkg::HOUR_TICKS - 1)) begin
                hour_cnt <= '0;
                hours    <= hours + 32'd1;
            end else begin
                hour_cnt <= hour_cnt + 16'd1;
            end
        end
    end

    // =======================================================
    // switching outputs, active low with inversion off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            warning_output       <= 1'b1;
            failure_output       <= 1'b1;
            heartbeat_output     <= 1'b1;
            rotor_turning_output <= 1'b1;
            pump_running         <= 1'b0;
            reset_confirm        <= 1'b0;
        end else begin
            warning_output       <= invert ^ !(warn_now || fail_latch);
            failure_output       <= invert ^ !fail_latch;
            heartbeat_output     <= invert ^ (hb_cnt >= 8'(pcm_pkg::HEARTBEAT_LOW));
            rotor_turning_output <= invert ^ !vib_state[2];
            pump_running         <= vib_state[2];
            reset_confirm        <= confirm_cnt != 8'd0;
        end
    end

    // =======================================================
    // axi4-lite slave
    logic        aw_held, w_held;
    logic [31:0] rd_word;
    logic        rd_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= '0;
            wr_data      <= '0;
            wr_strb      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pcm_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr <= pcm_pkg::ADDR_READINGS) ?
                                pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            pcm_pkg::ADDR_CTRL:      rd_word[pcm_pkg::CTRL_INVERT] = invert;
            pcm_pkg::ADDR_STATUS: begin
                rd_word[pcm_pkg::ST_WARN]      = warn_now;
                rd_word[pcm_pkg::ST_FAIL]      = fail_latch;
                rd_word[pcm_pkg::ST_TURNING]   = vib_state[2];
                rd_word[pcm_pkg::ST_STARTUP]   = startup;
                rd_word[pcm_pkg::ST_CONFIRM]   = confirm_cnt != 8'd0;
                rd_word[pcm_pkg::ST_HEARTBEAT] = hb_cnt >= 8'(pcm_pkg::HEARTBEAT_LOW);
                rd_word[pcm_pkg::ST_FAIL_NOW]  = fail_now;
            end
            pcm_pkg::ADDR_VIB_WARN:  rd_word = 32'(vib_warn_lim);
            pcm_pkg::ADDR_VIB_FAIL:  rd_word = 32'(vib_fail_lim);
            pcm_pkg::ADDR_HYST:      rd_word = 32'(hyst);
            pcm_pkg::ADDR_TEMP_WARN: rd_word = 32'(temp_warn_lim);
            pcm_pkg::ADDR_TEMP_FAIL: rd_word = 32'(temp_fail_lim);
            pcm_pkg::ADDR_RUN_THR:   rd_word = 32'(run_thr);
            pcm_pkg::ADDR_HOURS:     rd_word = hours;
            pcm_pkg::ADDR_READINGS: begin
                rd_word[TEMP_W-1:0] = temp;
                rd_word[pcm_pkg::RD_VIB_POS +: VIB_W] = vib;
            end
            default:                 rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= pcm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : pcm_monitor

// file: verification/pcm_props.sv
// checker on the monitor's switching outputs
// assumes invert stays off; counts scale with TICK_CYCLES
`timescale 1ns/1ps
module pcm_chk #(
    parameter int unsigned TEMP_W      = 8,
    parameter int unsigned TICK_CYCLES = 10
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // sensor and outputs
    input wire logic [TEMP_W-1:0] oil_temperature_probe,
    input wire logic              warning_output,
    input wire logic              failure_output,
    input wire logic              heartbeat_output,
    input wire logic              rotor_turning_output,
    input wire logic              pump_running,
    input wire logic              reset_confirm
);
    localparam int HB = 5 * TICK_CYCLES;
    localparam int HL = 2 * TICK_CYCLES;
    // confirm starts at any phase of the tick, so its end is known to one tick
    localparam int CL = 24 * TICK_CYCLES;
    localparam int CT = TICK_CYCLES;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // =========================================================
    // assertions
    // six cycles cover the two-flop pass and the output register
    AST_TEMP_WARN: assert property ((oil_temperature_probe >= 8'h3C) [*6] |-> !warning_output)
        else $error("temperature warning missing");
    AST_TEMP_FAIL: assert property ((oil_temperature_probe >= 8'h46) [*6] |-> !failure_output)
        else $error("temperature failure missing");
    AST_FAIL_WARN: assert property (!failure_output |-> !warning_output)
        else $error("failure without warning");
    AST_FAIL_LATCH: assert property ($rose(failure_output) |-> ##[0:2] reset_confirm)
        else $error("failure released without reset");
    AST_RUN: assert property (pump_running == !rotor_turning_output)
        else $error("running and rotor outputs disagree");
    AST_HB_PERIOD: assert property ($fell(heartbeat_output) && $past(resetn, 2) |-> ##HB $fell(heartbeat_output))
        else $error("heartbeat period wrong");
    AST_HB_LOW: assert property ($rose(heartbeat_output) |-> !$past(heartbeat_output, HL))
        else $error("heartbeat low phase wrong");
    AST_CONFIRM: assert property ($rose(reset_confirm) |-> ##CL reset_confirm ##[1:CT] !reset_confirm)
        else $error("confirm length wrong");
    COV_FAIL: cover property ($fell(failure_output));
    COV_CONF: cover property ($rose(reset_confirm));
    COV_RUN: cover property ($rose(pump_running));
endmodule : pcm_chk
bind pcm_monitor pcm_chk #(.TEMP_W(TEMP_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (.clk, .resetn,
    .oil_temperature_probe, .warning_output, .failure_output, .heartbeat_output,
    .rotor_turning_output, .pump_running, .reset_confirm);

// file: verification/pcm_plant.sv
// plant controller model: checks its pump command against rotor feedback
// assumes rotor output low means turning
`timescale 1ns/1ps
module pcm_plant #(
    parameter int unsigned GRACE = 150
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // command and feedback
    input  wire logic pump_on_cmd,
    input  wire logic rotor_turning_output,
    output logic      mismatch
);
    int unsigned cnt;
    // feedback lags the command by the debounce, hence the grace span
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
        end else if (pump_on_cmd == rotor_turning_output) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end
    assign mismatch = (cnt >= GRACE);
endmodule : pcm_plant

// file: verification/pump_condition_monitor_tb.sv
// bench: register access over axi4-lite, sensor stimulus, output checks
// assumes TICK_CYCLES of 10 so a tick is 10 clocks
`timescale 1ns/1ps
module pump_condition_monitor_tb;
    localparam int TK = 10;
    logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, reset_button_n, warning_output, failure_output, heartbeat_output;
    logic rotor_turning_output, pump_running, reset_confirm, pump_on_cmd, mismatch;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, oil_temperature_probe;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [9:0]  vibration_level;
    int fails = 0;
    int comparisons = 0;
    int n;
    logic [31:0] dflt [6] = '{32'h64, 32'h96, 32'hA, 32'h3C, 32'h46, 32'hF};
    pcm_monitor #(.TICK_CYCLES(TK)) uut (.*);
    pcm_plant u_plant (.clk, .resetn, .pump_on_cmd, .rotor_turning_output, .mismatch);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic so(input logic [3:0] e);
        chk({28'h0, warning_output, failure_output, rotor_turning_output, pump_running}, {28'h0, e});
    endtask : so
    task automatic tk(input int n);
        repeat (n * TK) @(posedge clk);
    endtask : tk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, pcm_pkg::RESP_OKAY});
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic pb(input int n);
        reset_button_n <= 1'b0;
        tk(n);
        reset_button_n <= 1'b1;
        tk(3);
    endtask : pb
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pump_on_cmd, vibration_level} = '0;
        s_axi_wstrb = 4'hF;
        reset_button_n = 1'b1;
        oil_temperature_probe = 8'h19;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        foreach (dflt[i]) begin
            rd(8'h08 + 8'(4 * i));
            chk(d, dflt[i]);
        end
        n = 0;
        repeat (pcm_pkg::HEARTBEAT_TICKS * TK) begin
            @(posedge clk);
            n += !heartbeat_output;
        end
        chk(n, pcm_pkg::HEARTBEAT_LOW * TK);
        rd(8'h28);
        chk({30'h0, r}, {30'h0, pcm_pkg::RESP_SLVERR});
        oil_temperature_probe <= 8'h3C;
        tk(1);
        so(4'b0110);
        oil_temperature_probe <= 8'h3B;
        tk(1);
        so(4'b1110);
        wr(pcm_pkg::ADDR_TEMP_WARN, 32'h32);
        oil_temperature_probe <= 8'h37;
        tk(1);
        so(4'b0110);
        wr(pcm_pkg::ADDR_TEMP_WARN, 32'h3C);
        oil_temperature_probe <= 8'h46;
        tk(1);
        so(4'b0010);
        for (int k = 0; k < 2; k++) begin
            oil_temperature_probe <= k ? 8'h28 : 8'h46;
            tk(1);
            so(4'b0010);
            pb(16);
            pb(2);
            pb(2);
            chk({31'h0, reset_confirm}, k);
            so(k ? 4'b1110 : 4'b0010);
        end
        tk(26);
        vibration_level <= 10'h14;
        pump_on_cmd <= 1'b1;
        tk(5);
        so(4'b1110);
        vibration_level <= 10'h78;
        tk(7);
        so(4'b1101);
        chk({31'h0, mismatch}, 0);
        tk(15);
        so(4'b1101);
        tk(25);
        so(4'b0101);
        vibration_level <= 10'hA0;
        tk(13);
        so(4'b0001);
        vibration_level <= 10'h0;
        tk(30);
        so(4'b0010);
        chk({31'h0, mismatch}, 1);
        end_of_test();
    end
    initial begin
        #60000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule : pump_condition_monitor_tb
